// file: logic/cprc_pkg.sv
/*
 Constants, register map and carrier types of the clock, power and reset controller.
 Assumes a single 25 MHz reference clock and a 32-bit Avalon-MM register bus.
*/
// What this block does
// - Main crystal stops on deep sleep or when its halt bit is set.
// - Processor runs from fast internal oscillator after reset release.
// - Fast internal oscillator halts on deep sleep or its halt bit.
// - Fast oscillator frequency loads from option byte; software may change it, 64 MHz max.
// - External main clock input disabled on deep sleep or main halt bit.
// - Sub crystal or its external input stops only by the sub halt bit.
// - Slow internal oscillator never clocks the processor; feeds four peripherals only.
// - Internal reset held while supply is below the power-up threshold.
// - Level detector gives reset or interrupt, mode and threshold from option byte.
// - Level detector keeps working in deep sleep.
// - Sleep gates processor clock; running fast oscillators keep running.
// - Deep sleep stops fast oscillators; an interrupt request ends it.
// - Leaving deep sleep on main crystal waits for oscillation to settle.
// - Low-power modes leave all registers and flags unchanged.
// - Seven reset sources: pin, watchdog, power-up, level, parity, illegal access, software.
// - Every reset restarts from the vector held at 0000H and 0001H.
// - Watchdog counts slow oscillator ticks in 17 bits, resets on overflow.
// - Watchdog resets on bit access, wrong kick value, or kick while window closed.
package cprc_pkg;
	localparam int REF_CLK_HZ = 25_000_000;
	localparam int SLOW_OSC_HZ = 15_000;
	localparam int SLOW_TICK_CYCLES = REF_CLK_HZ / SLOW_OSC_HZ;
	localparam int OSC_STAB_CYCLES = 2048;
	localparam int RESET_HOLD_CYCLES = 16;
	localparam int WDT_WIDTH = 17;

	localparam logic [4:0] OFS_CLK_CTRL = 5'h00;
	localparam logic [4:0] OFS_FAST_FREQ = 5'h04;
	localparam logic [4:0] OFS_WDT_KICK = 5'h08;
	localparam logic [4:0] OFS_WDT_KICK_BITOP = 5'h0C;
	localparam logic [4:0] OFS_SW_RESET = 5'h10;
	localparam logic [4:0] OFS_RESET_CAUSE = 5'h14;
	localparam logic [4:0] OFS_STATUS = 5'h18;
	localparam logic [4:0] OFS_WDT_COUNT = 5'h1C;

	localparam logic [7:0] WDT_KICK_VALUE = 8'hAC;
	localparam logic [7:0] SW_RESET_KEY = 8'h5A;
	localparam logic [15:0] RESET_VECTOR_ADDR = 16'h0000;

	// Processor clock choices; the slow oscillator has no code
	localparam logic [1:0] CPU_SEL_FAST = 2'h0;
	localparam logic [1:0] CPU_SEL_MAIN = 2'h1;
	localparam logic [1:0] CPU_SEL_SUB = 2'h2;

	// Reset cause bit positions
	localparam int RC_PIN = 0;
	localparam int RC_WDT = 1;
	localparam int RC_POR = 2;
	localparam int RC_LVD = 3;
	localparam int RC_PARITY = 4;
	localparam int RC_ILLEGAL = 5;
	localparam int RC_SOFT = 6;
	localparam int RC_COUNT = 7;

	typedef struct packed {
		logic [1:0] cpu_sel;
		logic sub_osc_halt_bit;
		logic fast_internal_osc_halt_bit;
		logic main_osc_halt_bit;
	} cprc_clk_ctrl_s;

	localparam cprc_clk_ctrl_s CLK_CTRL_RESET = '{cpu_sel: CPU_SEL_FAST, sub_osc_halt_bit: 1'b1,
		fast_internal_osc_halt_bit: 1'b0, main_osc_halt_bit: 1'b1};

	typedef struct packed {
		logic [2:0] fast_freq;
		logic lvd_irq_mode;
		logic [1:0] lvd_level;
		logic [1:0] wdt_period;
		logic [1:0] wdt_window;
	} cprc_option_s;

	typedef enum logic [1:0] {
		PM_RUN,
		PM_SLEEP,
		PM_DEEP,
		PM_STAB
	} cprc_pmode_e;
endpackage : cprc_pkg

// file: logic/cprc_top.sv
/*
 Clock source control, low-power modes, reset merging and windowed watchdog.
 Assumes all inputs synchronous to i_ref_clk; analog comparators and oscillator pads are outside.
*/
`timescale 1ns/1ns
module cprc_top
	import cprc_pkg::*;
#(
	parameter int STAB_CYCLES = OSC_STAB_CYCLES,
	parameter int HOLD_CYCLES = RESET_HOLD_CYCLES
)
(
	input wire logic i_ref_clk,
	input wire logic i_srst,
	input wire logic [4:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	input wire cprc_option_s i_option,
	input wire logic i_external_reset_pin_n,
	input wire logic i_supply_above_power_up_threshold,
	input wire logic i_supply_below_detect_threshold,
	input wire logic i_ram_parity_error,
	input wire logic i_illegal_access,
	input wire logic i_sleep_exec,
	input wire logic i_deep_sleep_exec,
	input wire logic i_irq_request,
	output logic o_main_osc_en,
	output logic o_main_ext_clk_en,
	output logic o_fast_osc_en,
	output logic [2:0] o_fast_osc_freq,
	output logic o_sub_osc_en,
	output logic o_sub_ext_clk_en,
	output logic [1:0] o_cpu_clk_sel,
	output logic o_cpu_clk_en,
	output logic [3:0] o_slow_osc_route_en,
	output logic [1:0] o_detect_threshold_sel,
	output logic o_lvd_irq,
	output logic o_sys_reset,
	output logic [15:0] o_reset_vector_addr
);
	localparam int TICK_W = $clog2(SLOW_TICK_CYCLES + 1);
	localparam int STAB_W = $clog2(STAB_CYCLES + 1);
	localparam int HOLD_W = $clog2(HOLD_CYCLES + 1);

	// Overflow limit from option: 2^14 .. 2^17 slow ticks
	function automatic logic [WDT_WIDTH:0] wdt_limit(input logic [1:0] period);
		wdt_limit = (WDT_WIDTH + 1)'(1) << (5'd14 + 5'(period));
	endfunction : wdt_limit

	// Window open: always, last 75 %, last 50 % or last 25 % of the period
	function automatic logic wdt_window_open(input logic [WDT_WIDTH-1:0] cnt, input logic [1:0] period,
		input logic [1:0] win);
		logic [WDT_WIDTH:0] lim;
		logic [WDT_WIDTH:0] c;
		lim = wdt_limit(period);
		c = {1'b0, cnt};
		case (win)
			2'd0: wdt_window_open = 1'b1;
			2'd1: wdt_window_open = c >= (lim >> 2);
			2'd2: wdt_window_open = c >= (lim >> 1);
			default: wdt_window_open = c >= ((lim >> 1) + (lim >> 2));
		endcase
	endfunction : wdt_window_open

	cprc_clk_ctrl_s clk_ctrl;
	cprc_option_s opt;
	cprc_pmode_e pmode;
	logic [2:0] fast_freq;
	logic [RC_COUNT-1:0] reset_cause;
	logic [RC_COUNT-1:0] reset_src;
	logic [HOLD_W-1:0] hold_cnt;
	logic [STAB_W-1:0] stab_cnt;
	logic [TICK_W-1:0] tick_cnt;
	logic slow_tick;
	logic [WDT_WIDTH-1:0] wdt_cnt;
	logic wdt_fault;
	logic soft_reset_req;
	logic bus_req;
	logic bus_done;
	logic local_rst;
	logic [31:0] next_readdata;
	logic wr_clk_ctrl;
	logic wr_fast_freq;
	logic wr_kick;
	logic wr_cause;
	logic kick_ok;

	assign bus_req = i_avs_read | i_avs_write;
	// Access completes at the edge where waitrequest is low
	assign bus_done = bus_req & ~o_avs_waitrequest;
	// Clock, power-mode, option and watchdog state returns to defaults on power-on and on every merged reset
	assign local_rst = i_srst | o_sys_reset;
	assign wr_clk_ctrl = bus_done & i_avs_write & (i_avs_address == OFS_CLK_CTRL) & i_avs_byteenable[0];
	assign wr_fast_freq = bus_done & i_avs_write & (i_avs_address == OFS_FAST_FREQ) & i_avs_byteenable[0];
	assign wr_kick = bus_done & i_avs_write & (i_avs_address == OFS_WDT_KICK);
	assign wr_cause = bus_done & i_avs_write & (i_avs_address == OFS_RESET_CAUSE) & i_avs_byteenable[0];
	assign kick_ok = wr_kick & (i_avs_writedata[7:0] == WDT_KICK_VALUE) & i_avs_byteenable[0]
		& wdt_window_open(wdt_cnt, opt.wdt_period, opt.wdt_window);

	// Bus handshake: one wait state, then one completing cycle
	always_ff @(posedge i_ref_clk)
	begin
		if (i_srst)
			o_avs_waitrequest <= 1'b1;
		else
			o_avs_waitrequest <= ~(bus_req & o_avs_waitrequest);
	end

	always_comb
	begin
		next_readdata = 32'h0000_0000;
		case (i_avs_address)
			OFS_CLK_CTRL: next_readdata = {27'h000_0000, clk_ctrl};
			OFS_FAST_FREQ: next_readdata = {29'h0000_0000, fast_freq};
			OFS_RESET_CAUSE: next_readdata = {25'h000_0000, reset_cause};
			OFS_STATUS: next_readdata = {27'h000_0000, i_supply_below_detect_threshold,
				(pmode == PM_STAB), 2'(pmode), o_sys_reset};
			OFS_WDT_COUNT: next_readdata = {15'h0000, wdt_cnt};
			default: next_readdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (i_srst)
			o_avs_readdata <= 32'h0000_0000;
		else if (i_avs_read & o_avs_waitrequest)
			o_avs_readdata <= next_readdata;
	end

	// Options are sampled throughout reset and frozen at its release
	always_ff @(posedge i_ref_clk)
	begin
		if (local_rst)
			opt <= i_option;
	end

	// Clock control register
	always_ff @(posedge i_ref_clk)
	begin
		if (local_rst)
			clk_ctrl <= CLK_CTRL_RESET;
		else if (wr_clk_ctrl)
		begin
			clk_ctrl.main_osc_halt_bit <= i_avs_writedata[0];
			clk_ctrl.fast_internal_osc_halt_bit <= i_avs_writedata[1];
			clk_ctrl.sub_osc_halt_bit <= i_avs_writedata[2];
			if (i_avs_writedata[4:3] != 2'h3)
				clk_ctrl.cpu_sel <= i_avs_writedata[4:3];
		end
	end

	// Fast oscillator frequency code
	always_ff @(posedge i_ref_clk)
	begin
		if (local_rst)
			fast_freq <= i_option.fast_freq;
		else if (wr_fast_freq)
			fast_freq <= i_avs_writedata[2:0];
	end

	// Low-power mode sequencing; no register is touched on entry or exit
	always_ff @(posedge i_ref_clk)
	begin
		if (local_rst)
		begin
			pmode <= PM_RUN;
			stab_cnt <= '0;
		end
		else
		begin
			case (pmode)
				PM_RUN:
				begin
					if (i_deep_sleep_exec)
						pmode <= PM_DEEP;
					else if (i_sleep_exec)
						pmode <= PM_SLEEP;
				end
				PM_SLEEP:
				begin
					if (i_irq_request)
						pmode <= PM_RUN;
				end
				PM_DEEP:
				begin
					if (i_irq_request)
					begin
						if (clk_ctrl.cpu_sel == CPU_SEL_MAIN)
						begin
							pmode <= PM_STAB;
							stab_cnt <= STAB_W'(STAB_CYCLES - 1);
						end
						else
							pmode <= PM_RUN;
					end
				end
				PM_STAB:
				begin
					if (stab_cnt == '0)
						pmode <= PM_RUN;
					else
						stab_cnt <= stab_cnt - 1'b1;
				end
				default: pmode <= PM_RUN;
			endcase
		end
	end

	// Oscillator enables
	always_ff @(posedge i_ref_clk)
	begin
		if (local_rst)
		begin
			o_main_osc_en <= 1'b0;
			o_main_ext_clk_en <= 1'b0;
			o_fast_osc_en <= 1'b1;
			o_sub_osc_en <= 1'b0;
			o_sub_ext_clk_en <= 1'b0;
			o_cpu_clk_en <= 1'b0;
		end
		else
		begin
			o_main_osc_en <= ~clk_ctrl.main_osc_halt_bit & (pmode != PM_DEEP);
			o_main_ext_clk_en <= ~clk_ctrl.main_osc_halt_bit & (pmode != PM_DEEP);
			o_fast_osc_en <= ~clk_ctrl.fast_internal_osc_halt_bit & (pmode != PM_DEEP);
			o_sub_osc_en <= ~clk_ctrl.sub_osc_halt_bit;
			o_sub_ext_clk_en <= ~clk_ctrl.sub_osc_halt_bit;
			o_cpu_clk_en <= (pmode == PM_RUN);
		end
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (local_rst)
		begin
			o_cpu_clk_sel <= CPU_SEL_FAST;
			o_fast_osc_freq <= 3'h0;
		end
		else
		begin
			o_cpu_clk_sel <= clk_ctrl.cpu_sel;
			o_fast_osc_freq <= fast_freq;
		end
	end

	// Slow oscillator to watchdog, calendar, interval timer, general timer
	always_ff @(posedge i_ref_clk)
	begin
		if (i_srst)
			o_slow_osc_route_en <= 4'h0;
		else
			o_slow_osc_route_en <= 4'hF;
	end

	// Level detector; runs regardless of low-power mode
	always_ff @(posedge i_ref_clk)
	begin
		if (i_srst)
		begin
			o_detect_threshold_sel <= 2'h0;
			o_lvd_irq <= 1'b0;
		end
		else
		begin
			o_detect_threshold_sel <= opt.lvd_level;
			o_lvd_irq <= opt.lvd_irq_mode & i_supply_below_detect_threshold;
		end
	end

	// Slow oscillator tick derived from the reference clock
	always_ff @(posedge i_ref_clk)
	begin
		if (i_srst | (tick_cnt == TICK_W'(SLOW_TICK_CYCLES - 1)))
			tick_cnt <= '0;
		else
			tick_cnt <= tick_cnt + 1'b1;
	end
	assign slow_tick = (tick_cnt == TICK_W'(SLOW_TICK_CYCLES - 1));

	// Watchdog counter
	always_ff @(posedge i_ref_clk)
	begin
		if (local_rst)
			wdt_cnt <= '0;
		else if (kick_ok)
			wdt_cnt <= '0;
		else if (slow_tick)
			wdt_cnt <= wdt_cnt + 1'b1;
	end

	always_comb
	begin
		wdt_fault = 1'b0;
		if (slow_tick & ({1'b0, wdt_cnt} == wdt_limit(opt.wdt_period) - 1'b1))
			wdt_fault = 1'b1;
		if (bus_done & (i_avs_address == OFS_WDT_KICK_BITOP))
			wdt_fault = 1'b1;
		if (wr_kick & ~kick_ok)
			wdt_fault = 1'b1;
	end

	assign soft_reset_req = bus_done & i_avs_write & (i_avs_address == OFS_SW_RESET)
		& i_avs_byteenable[0] & (i_avs_writedata[7:0] == SW_RESET_KEY);

	always_comb
	begin
		reset_src = '0;
		reset_src[RC_PIN] = ~i_external_reset_pin_n;
		reset_src[RC_WDT] = wdt_fault & ~o_sys_reset;
		reset_src[RC_POR] = ~i_supply_above_power_up_threshold;
		reset_src[RC_LVD] = ~opt.lvd_irq_mode & i_supply_below_detect_threshold;
		reset_src[RC_PARITY] = i_ram_parity_error;
		reset_src[RC_ILLEGAL] = i_illegal_access;
		reset_src[RC_SOFT] = soft_reset_req & ~o_sys_reset;
	end

	// Sticky reset causes, survive merged reset; set wins over clear
	always_ff @(posedge i_ref_clk)
	begin
		if (i_srst)
			reset_cause <= 7'h04;
		else
			reset_cause <= (reset_cause & ~(wr_cause ? i_avs_writedata[6:0] : 7'h00)) | reset_src;
	end

	// Merged reset and stretch
	always_ff @(posedge i_ref_clk)
	begin
		// Hold while active, release on clock
		if (i_srst | (|reset_src))
		begin
			o_sys_reset <= 1'b1;
			hold_cnt <= HOLD_W'(HOLD_CYCLES);
		end
		else if (hold_cnt != '0)
		begin
			o_sys_reset <= 1'b1;
			hold_cnt <= hold_cnt - 1'b1;
		end
		else
			o_sys_reset <= 1'b0;
	end

	// Same restart vector for every source
	always_ff @(posedge i_ref_clk)
	begin
		if (i_srst)
			o_reset_vector_addr <= RESET_VECTOR_ADDR;
		else
			o_reset_vector_addr <= RESET_VECTOR_ADDR;
	end
endmodule : cprc_top

// file: testbench/cprc_sva.sv
/*
 Port checker for the clock, power and reset controller.
 Assumes the option byte stays steady once the controller leaves reset.
*/
`timescale 1ns/1ns
module cprc_sva
	import cprc_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_srst,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic o_avs_waitrequest,
	input wire cprc_option_s i_option,
	input wire logic i_external_reset_pin_n,
	input wire logic i_supply_above_power_up_threshold,
	input wire logic i_supply_below_detect_threshold,
	input wire logic i_ram_parity_error,
	input wire logic i_illegal_access,
	input wire logic i_sleep_exec,
	input wire logic i_deep_sleep_exec,
	input wire logic i_irq_request,
	input wire logic o_main_osc_en,
	input wire logic o_main_ext_clk_en,
	input wire logic o_fast_osc_en,
	input wire logic [1:0] o_cpu_clk_sel,
	input wire logic o_cpu_clk_en,
	input wire logic [3:0] o_slow_osc_route_en,
	input wire logic o_lvd_irq,
	input wire logic o_sys_reset,
	input wire logic [15:0] o_reset_vector_addr
);
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_srst);
	logic src;
	assign src = !i_external_reset_pin_n || !i_supply_above_power_up_threshold || i_ram_parity_error
		|| i_illegal_access || (i_supply_below_detect_threshold && !i_option.lvd_irq_mode);
	// Mode request while settled in run
	sequence s_run_pulse(p);
		p && o_cpu_clk_en && $past(o_cpu_clk_en) && !o_sys_reset && !src
			&& !$past(i_sleep_exec || i_deep_sleep_exec);
	endsequence
	// Halted on main crystal with a wake request
	sequence s_deep_main;
		!o_cpu_clk_en && !o_main_osc_en && o_cpu_clk_sel == CPU_SEL_MAIN && !o_sys_reset && i_irq_request;
	endsequence
	AST_DEEP_STOP: assert property (s_run_pulse(i_deep_sleep_exec) |-> ##2 !o_main_osc_en
		&& !o_fast_osc_en && !o_main_ext_clk_en && !o_cpu_clk_en) else $error("deep sleep left a clock on");
	AST_SLEEP_KEEP: assert property (s_run_pulse(i_sleep_exec && !i_deep_sleep_exec) |-> ##1
		($stable(o_fast_osc_en) && $stable(o_main_osc_en))[*2] ##0 !o_cpu_clk_en) else $error("sleep moved a clock");
	AST_STAB_WAIT: assert property (s_deep_main |=> ##1 (!o_cpu_clk_en)[*6])
		else $error("main crystal wake did not wait");
	AST_SLOW_ROUTE: assert property (!$past(i_srst) |-> o_cpu_clk_sel != 2'h3 && o_slow_osc_route_en == 4'hF)
		else $error("slow oscillator routing wrong");
	AST_SRC_RESET: assert property (src |=> o_sys_reset[*2])
		else $error("reset source not merged");
	AST_RELEASE: assert property ($fell(o_sys_reset) |-> !$past(src) && o_reset_vector_addr == RESET_VECTOR_ADDR)
		else $error("reset released badly");
	AST_LVD_IRQ: assert property (i_supply_below_detect_threshold && i_option.lvd_irq_mode |=> o_lvd_irq)
		else $error("detector request missing");
	AST_BUS_ONE: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest
		##1 o_avs_waitrequest) else $error("bus answer not one cycle");
endmodule : cprc_sva

// file: testbench/cprc_pins.sv
/*
 Far side: reset button, supply monitor and detector comparator.
 Assumes requests come from the bench on the reference clock.
*/
`timescale 1ns/1ns
module cprc_pins
(
	input wire logic i_ref_clk,
	input wire logic i_press,
	input wire logic i_brownout,
	input wire logic i_sag,
	output logic o_external_reset_pin_n,
	output logic o_supply_ok,
	output logic o_below
);
	initial
	begin
		o_external_reset_pin_n = 1'b1;
		o_supply_ok = 1'b1;
		o_below = 1'b0;
	end
	always @(posedge i_ref_clk)
	begin
		o_external_reset_pin_n <= !i_press;
		o_supply_ok <= !i_brownout;
		o_below <= i_sag;
	end
endmodule : cprc_pins

// file: testbench/testbench.sv
/*
 Self-checking bench for the clock, power and reset controller.
 Assumes shortened settle counts; each bus access waits for the slave's answer.
*/
`timescale 1ns/1ns
module testbench;
	import cprc_pkg::*;
	localparam int STAB = 8;
	localparam int HOLD = 2;
	logic i_ref_clk = 1'b0;
	logic i_srst = 1'b1;
	logic [4:0] i_avs_address = 5'h0;
	logic i_avs_read = 1'b0;
	logic i_avs_write = 1'b0;
	logic [31:0] i_avs_writedata = 32'h0;
	logic [3:0] i_avs_byteenable = 4'hF;
	cprc_option_s i_option = '{fast_freq: 3'h5, lvd_irq_mode: 1'b0, lvd_level: 2'h2, wdt_period: 2'h0,
		wdt_window: 2'h0};
	logic press = 1'b0, brown = 1'b0, sag = 1'b0;
	logic i_ram_parity_error = 1'b0, i_illegal_access = 1'b0, i_sleep_exec = 1'b0;
	logic i_deep_sleep_exec = 1'b0, i_irq_request = 1'b0;
	logic i_external_reset_pin_n, i_supply_above_power_up_threshold, i_supply_below_detect_threshold;
	logic [31:0] o_avs_readdata;
	logic o_avs_waitrequest, o_main_osc_en, o_main_ext_clk_en, o_fast_osc_en, o_sub_osc_en, o_sub_ext_clk_en;
	logic [2:0] o_fast_osc_freq;
	logic [1:0] o_cpu_clk_sel, o_detect_threshold_sel;
	logic o_cpu_clk_en, o_lvd_irq, o_sys_reset;
	logic [3:0] o_slow_osc_route_en;
	logic [15:0] o_reset_vector_addr;
	logic [31:0] got;
	int err_count = 0;
	int checks = 0;
	int cycles = 0;
	cprc_top #(.STAB_CYCLES(STAB), .HOLD_CYCLES(HOLD)) cprc_top_i (.i_ref_clk, .i_srst, .i_avs_address,
		.i_avs_read, .i_avs_write, .i_avs_writedata, .i_avs_byteenable, .o_avs_readdata, .o_avs_waitrequest,
		.i_option, .i_external_reset_pin_n, .i_supply_above_power_up_threshold, .i_supply_below_detect_threshold,
		.i_ram_parity_error, .i_illegal_access, .i_sleep_exec, .i_deep_sleep_exec, .i_irq_request,
		.o_main_osc_en, .o_main_ext_clk_en, .o_fast_osc_en, .o_fast_osc_freq, .o_sub_osc_en, .o_sub_ext_clk_en,
		.o_cpu_clk_sel, .o_cpu_clk_en, .o_slow_osc_route_en, .o_detect_threshold_sel, .o_lvd_irq,
		.o_sys_reset, .o_reset_vector_addr);
	cprc_pins cprc_pins_i (.i_ref_clk, .i_press(press), .i_brownout(brown), .i_sag(sag),
		.o_external_reset_pin_n(i_external_reset_pin_n), .o_supply_ok(i_supply_above_power_up_threshold),
		.o_below(i_supply_below_detect_threshold));
	initial
	begin
		forever #20 i_ref_clk = ~i_ref_clk;
	end
	task automatic end_of_test();
		$display("checks %0d errors %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : end_of_test
	always @(posedge i_ref_clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 5000)
		begin
			err_count++;
			end_of_test();
		end
	end
	task automatic cmp(input logic [31:0] act, input logic [31:0] exp);
		checks++;
		if (act !== exp)
		begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, act, exp);
		end
	endtask : cmp
	// Request held until waitrequest is seen low
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
		@(posedge i_ref_clk);
		i_avs_read <= !w;
		i_avs_write <= w;
		i_avs_address <= a;
		i_avs_writedata <= d;
		do @(posedge i_ref_clk); while (o_avs_waitrequest !== 1'b0);
		got = o_avs_readdata;
		i_avs_read <= 1'b0;
		i_avs_write <= 1'b0;
	endtask : bus
	task automatic tick(input int n);
		repeat (n) @(posedge i_ref_clk);
		@(negedge i_ref_clk);
	endtask : tick
	// Mask order: illegal, parity, irq, deep, sleep
	task automatic pulse(input logic [4:0] m);
		@(posedge i_ref_clk);
		{i_illegal_access, i_ram_parity_error, i_irq_request, i_deep_sleep_exec, i_sleep_exec} <= m;
		@(posedge i_ref_clk);
		{i_illegal_access, i_ram_parity_error, i_irq_request, i_deep_sleep_exec, i_sleep_exec} <= 5'h0;
		tick(2);
	endtask : pulse
	task automatic wait_rst();
		do @(negedge i_ref_clk); while (o_sys_reset !== 1'b1);
		do @(negedge i_ref_clk); while (o_sys_reset !== 1'b0);
	endtask : wait_rst
	initial
	begin
		repeat (10) @(posedge i_ref_clk);
		i_srst <= 1'b0;
		wait_rst();
		cmp(32'({o_slow_osc_route_en, o_cpu_clk_sel, o_fast_osc_en, o_main_osc_en, o_sub_osc_en,
			o_detect_threshold_sel, o_reset_vector_addr}), 32'({4'hF, CPU_SEL_FAST, 3'b100, 2'h2, 16'h0}));
		bus(1'b0, OFS_FAST_FREQ, 32'h0);
		cmp(got, 32'h5);
		bus(1'b0, OFS_RESET_CAUSE, 32'h0);
		cmp(got, 32'h4);
		bus(1'b1, OFS_FAST_FREQ, 32'h7);
		tick(2);
		cmp(32'(o_fast_osc_freq), 32'h7);
		tick(1700);
		bus(1'b0, OFS_WDT_COUNT, 32'h0);
		cmp(got, 32'h1);
		bus(1'b1, OFS_WDT_KICK, 32'(WDT_KICK_VALUE));
		bus(1'b0, OFS_WDT_COUNT, 32'h0);
		cmp({got[30:0], o_sys_reset}, 32'h0);
		bus(1'b1, OFS_CLK_CTRL, 32'h0);
		tick(2);
		cmp(32'({o_main_osc_en, o_main_ext_clk_en, o_fast_osc_en, o_sub_osc_en, o_sub_ext_clk_en}), 32'h1F);
		pulse(5'h02);
		cmp(32'({o_main_osc_en, o_main_ext_clk_en, o_fast_osc_en, o_sub_osc_en, o_cpu_clk_en}), 32'h2);
		pulse(5'h04);
		cmp(32'({o_main_osc_en, o_fast_osc_en, o_cpu_clk_en}), 32'h7);
		bus(1'b0, OFS_CLK_CTRL, 32'h0);
		cmp(got, 32'h0);
		bus(1'b0, OFS_FAST_FREQ, 32'h0);
		cmp(got, 32'h7);
		pulse(5'h01);
		cmp(32'({o_main_osc_en, o_fast_osc_en, o_cpu_clk_en}), 32'h6);
		pulse(5'h04);
		bus(1'b1, OFS_CLK_CTRL, 32'h8);
		tick(2);
		cmp(32'(o_cpu_clk_sel), 32'(CPU_SEL_MAIN));
		pulse(5'h02);
		pulse(5'h04);
		cmp(32'(o_cpu_clk_en), 32'h0);
		bus(1'b0, OFS_STATUS, 32'h0);
		cmp(got, 32'hE);
		tick(STAB + 4);
		cmp(32'(o_cpu_clk_en), 32'h1);
		bus(1'b1, OFS_CLK_CTRL, 32'h7);
		tick(2);
		cmp(32'({o_main_osc_en, o_main_ext_clk_en, o_fast_osc_en, o_sub_osc_en, o_sub_ext_clk_en}), 32'h0);
		for (int k = 0; k < 8; k++)
		begin
			bus(1'b1, OFS_RESET_CAUSE, 32'h7F);
			bus(1'b1, OFS_CLK_CTRL, 32'h0);
			@(posedge i_ref_clk);
			case (k)
				0: press <= 1'b1;
				1: bus(1'b1, OFS_WDT_KICK, 32'h11);
				2: brown <= 1'b1;
				3: sag <= 1'b1;
				4: i_ram_parity_error <= 1'b1;
				5: i_illegal_access <= 1'b1;
				6: bus(1'b1, OFS_SW_RESET, 32'(SW_RESET_KEY));
				default: bus(1'b0, OFS_WDT_KICK_BITOP, 32'h0);
			endcase
			@(posedge i_ref_clk);
			{press, brown, sag, i_ram_parity_error, i_illegal_access} <= 5'h0;
			wait_rst();
			bus(1'b0, OFS_RESET_CAUSE, 32'h0);
			cmp(got, 32'h1 << (k == 7 ? RC_WDT : k));
			bus(1'b0, OFS_CLK_CTRL, 32'h0);
			cmp(got, 32'h5);
		end
		@(posedge i_ref_clk);
		i_srst <= 1'b1;
		i_option.lvd_irq_mode <= 1'b1;
		i_option.wdt_window <= 2'h1;
		tick(2);
		@(posedge i_ref_clk);
		i_srst <= 1'b0;
		wait_rst();
		bus(1'b1, OFS_WDT_KICK, 32'(WDT_KICK_VALUE));
		wait_rst();
		bus(1'b0, OFS_RESET_CAUSE, 32'h0);
		cmp(got, 32'h6);
		pulse(5'h02);
		@(posedge i_ref_clk);
		sag <= 1'b1;
		tick(3);
		cmp(32'({o_lvd_irq, o_sys_reset, o_cpu_clk_en}), 32'h4);
		end_of_test();
	end
endmodule : testbench
bind cprc_top cprc_sva cprc_sva_i (.i_ref_clk, .i_srst, .i_avs_read, .i_avs_write, .o_avs_waitrequest, .i_option,
	.i_external_reset_pin_n, .i_supply_above_power_up_threshold, .i_supply_below_detect_threshold,
	.i_ram_parity_error, .i_illegal_access, .i_sleep_exec, .i_deep_sleep_exec, .i_irq_request, .o_main_osc_en,
	.o_main_ext_clk_en, .o_fast_osc_en, .o_cpu_clk_sel, .o_cpu_clk_en, .o_slow_osc_route_en, .o_lvd_irq,
	.o_sys_reset, .o_reset_vector_addr);
